//--- shared/slr_pkg.sv
/*
  Shared constants, types and helpers for the sensor readout and
  seven-segment scanner: timing, segment patterns, conversion scaling.
  Assumes a single 100 MHz system clock.
*/
`default_nettype none

package slr_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int TICK_PERIOD_NS  = 500000000;
  localparam int TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
  // Kept in ns: the same span in ps would not fit a 32-bit int
  localparam int SCAN_PERIOD_NS  = 3276800;
  localparam int SCAN_CYCLES     = SCAN_PERIOD_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Conversion scaling
  // ---------------------------------------------------------------
  localparam int FULL_SCALE      = 1024;  // Code span of the converter
  localparam int LOAD_HUNDREDTHS = 1000;  // Load resistor, 0.01 kohm units
  localparam int DISP_LIMIT      = 10000; // Four digits
  localparam int DP_POS          = 2;     // Lowest integer digit
  localparam int RES_HI_MSB      = 7;
  localparam int RES_LO_MSB      = 7;
  localparam int RES_LO_LSB      = 6;

  // ---------------------------------------------------------------
  // Segment patterns, bit 7 is the decimal point
  // ---------------------------------------------------------------
  localparam logic [7:0] SEG_DP    = 8'h80;
  localparam logic [7:0] SEG_MINUS = 8'h40;
  localparam logic [9:0][7:0] SEG_DIGIT = {
    8'h6F, 8'h7F, 8'h27, 8'h7D, 8'h6D,
    8'h66, 8'h4F, 8'h5B, 8'h06, 8'h3F};
  localparam logic [3:0][7:0] DISP_RST = {
    8'h3F, 8'hBF, 8'h3F, 8'h3F};
  localparam logic [7:0] SEG_RST   = 8'h3F;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } slr_result_t;

  typedef enum logic [1:0] {
    SLR_IDLE,
    SLR_CHECK,
    SLR_DIV,
    SLR_STORE
  } slr_phase_t;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [13:0] slr_pow10(input logic [1:0] k);
    case (k)
      2'h3:    slr_pow10 = 14'h3E8;
      2'h2:    slr_pow10 = 14'h064;
      2'h1:    slr_pow10 = 14'h00A;
      default: slr_pow10 = 14'h001;
    endcase
  endfunction

  function automatic logic [7:0] slr_seg(input logic [3:0] d);
    if (d > 4'h9) begin
      slr_seg = SEG_MINUS;
    end else begin
      slr_seg = SEG_DIGIT[d];
    end
  endfunction

endpackage

`default_nettype wire

//--- logic/slr_top.sv
/*
  Sensor readout with a four-digit multiplexed seven-segment display.
  A half-second tick polls and restarts the converter, the result is
  turned into kohm digits, and a scan timer rotates the digits.
  Assumes a converter core on the same clock exposing a busy flag and
  a split result, and an external 2-to-4 decoder on the digit select.
*/
// Overview of operation
// - Half-second tick paces all measurements
// - Every tick starts a new conversion
// - Completion polled at next tick, no interrupt
// - Tick turns result into buffered display digits
// - Result shown as kohm with two decimals
// - Scan counter overflow selects next digit
// - Each digit lit 3.2768 ms, strict rotation
// - Overflow drives new digit pattern and select
// - Eight shared segment lines for all digits
// - Segment lines active high
// - Fixed digit and minus segment patterns
// - Decimal point on lowest integer digit
// - Two select lines feed 2-to-4 decoder
// - Most significant digit on fourth position
// - Start flag starts, clear aborts, reads busy
// - Upper eight bits high byte, two low
`timescale 1ns/1ps
`default_nettype none

module slr_top
  import slr_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int SCAN_CYC = SCAN_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // Converter
  input  wire logic        conv_busy_i,
  input  wire slr_result_t conv_result_i,
  output logic             conv_start_o,
  output logic             conv_abort_o,
  // Display
  output logic [7:0]       segment_outputs_o,
  output logic             digit_select_bit0_o,
  output logic             digit_select_bit1_o
);

  localparam int TW = $clog2(TICK_CYC);
  localparam int SW = $clog2(SCAN_CYC);

  typedef struct packed {
    logic [TW-1:0]    tick_cnt;
    logic [SW-1:0]    scan_cnt;
    logic [1:0]       sel;
    logic [7:0]       seg;
    logic [3:0][7:0]  disp;
    slr_phase_t       phase;
    logic             started;
    logic             restart;
    logic             start;
    logic             abort;
    logic             err;
    logic [9:0]       code;
    logic [23:0]      rem;
    logic [1:0]       k;
    logic [3:0]       dig;
    logic [3:0][3:0]  digits;
  } slr_state_t;

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic [1:0] rst_q;
  logic       rst_n;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end

  assign rst_n = rst_q[1];

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  slr_state_t s;
  slr_state_t next_s;
  logic       tick;
  logic       scan_ovf;
  logic [9:0] res_code;

  assign tick     = (s.tick_cnt == TW'(TICK_CYC - 1));
  assign scan_ovf = (s.scan_cnt == SW'(SCAN_CYC - 1));
  // Upper eight bits from the high byte, two from the low byte's top
  assign res_code = {conv_result_i.hi[RES_HI_MSB:0],
                     conv_result_i.lo[RES_LO_MSB:RES_LO_LSB]};

  always_comb begin
    logic [23:0] scaled;
    // Widen both factors first so the product cannot wrap at 14 bits
    scaled = 24'(s.code) * 24'(slr_pow10(s.k));
    next_s = s;
    next_s.start = 1'b0;
    next_s.abort = 1'b0;
    next_s.tick_cnt = tick ? '0 : s.tick_cnt + 1'b1;
    next_s.scan_cnt = scan_ovf ? '0 : s.scan_cnt + 1'b1;
    if (scan_ovf) begin
      next_s.sel = s.sel + 2'h1;
      next_s.seg = s.disp[next_s.sel];
    end
    if (s.restart) begin
      next_s.restart = 1'b0;
      next_s.start   = 1'b1;
      next_s.started = 1'b1;
    end
    if (tick) begin
      if (s.started && conv_busy_i) begin
        // Stale conversion: drop it, start afresh next cycle
        next_s.abort   = 1'b1;
        next_s.restart = 1'b1;
      end else begin
        next_s.start   = 1'b1;
        next_s.started = 1'b1;
        if (s.started) begin
          next_s.code  = res_code;
          next_s.phase = SLR_CHECK;
        end
      end
    end
    case (s.phase)
      SLR_CHECK: begin
        // Rs = RL * (1024 - N) / N, in hundredths of a kohm
        next_s.rem = 24'(LOAD_HUNDREDTHS * (FULL_SCALE - int'(s.code)));
        next_s.k   = 2'h3;
        next_s.dig = 4'h0;
        next_s.err = (s.code == 10'h000) ||
                     (next_s.rem >= 24'(int'(s.code) * DISP_LIMIT));
        next_s.phase = next_s.err ? SLR_STORE : SLR_DIV;
      end
      SLR_DIV: begin
        // One subtraction per cycle keeps the datapath to one adder
        if (s.rem >= scaled) begin
          next_s.rem = s.rem - scaled;
          next_s.dig = s.dig + 4'h1;
        end else begin
          next_s.digits[s.k] = s.dig;
          next_s.dig = 4'h0;
          if (s.k == 2'h0) begin
            next_s.phase = SLR_STORE;
          end else begin
            next_s.k = s.k - 2'h1;
          end
        end
      end
      SLR_STORE: begin
        for (int i = 0; i < 4; i++) begin
          // Out of range shows dashes on every position
          next_s.disp[i] = s.err ? SEG_MINUS : slr_seg(s.digits[i]);
          if (i == DP_POS && !s.err) begin
            next_s.disp[i] = next_s.disp[i] | SEG_DP;
          end
        end
        next_s.phase = SLR_IDLE;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s          <= '0;
      s.disp     <= DISP_RST;
      s.seg      <= SEG_RST;
      s.phase    <= SLR_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign conv_start_o        = s.start;
  assign conv_abort_o        = s.abort;
  assign segment_outputs_o   = s.seg;
  assign digit_select_bit0_o = s.sel[0];
  assign digit_select_bit1_o = s.sel[1];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  logic [31:0] tick_gap;
  logic [31:0] scan_gap;
  logic        tick_seen;
  logic        scan_seen;
  logic [7:0]  exp_seg;

  assign exp_seg = s.disp[s.sel + 2'h1];

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tick_gap  <= 32'h0;
      scan_gap  <= 32'h0;
      tick_seen <= 1'b0;
      scan_seen <= 1'b0;
    end else begin
      tick_gap  <= tick ? 32'h0 : tick_gap + 32'h1;
      scan_gap  <= scan_ovf ? 32'h0 : scan_gap + 32'h1;
      tick_seen <= tick_seen | tick;
      scan_seen <= scan_seen | scan_ovf;
    end
  end

  sequence seq_abort_restart;
    conv_abort_o ##1 conv_start_o;
  endsequence

  sequence seq_latch_code;
    ##1 (s.phase == SLR_CHECK && s.code == $past(res_code));
  endsequence

  chk_tick_period: assert property (tick && tick_seen |->
    tick_gap == 32'(TICK_CYC - 1))
    else $error("tick spacing wrong");
  chk_start_tick: assert property (tick && !(s.started && conv_busy_i)
    |=> conv_start_o && !conv_abort_o)
    else $error("no start on tick");
  chk_abort_busy: assert property (tick && s.started && conv_busy_i
    |=> seq_abort_restart)
    else $error("busy converter not aborted and restarted");
  chk_poll_latch: assert property (tick && s.started && !conv_busy_i
    |-> seq_latch_code)
    else $error("result not taken at tick");
  chk_scan_period: assert property (scan_ovf && scan_seen |->
    scan_gap == 32'(SCAN_CYC - 1))
    else $error("scan period wrong");
  chk_sel_rotate: assert property (scan_ovf |=>
    s.sel == $past(s.sel) + 2'h1)
    else $error("digit select out of order");
  chk_sel_hold: assert property (!scan_ovf |=> $stable(s.sel)
    && $stable(segment_outputs_o))
    else $error("display changed without overflow");
  chk_seg_follow: assert property (scan_ovf |=>
    segment_outputs_o == $past(exp_seg))
    else $error("segments not from new digit");
  chk_dp_place: assert property (s.phase == SLR_IDLE |->
    (s.disp[DP_POS][7] && !s.disp[0][7] && !s.disp[1][7]
     && !s.disp[3][7]) || s.disp == {4{SEG_MINUS}})
    else $error("decimal point misplaced");
  chk_div_bound: assert property ($rose(s.phase == SLR_CHECK) |->
    ##[1:45] s.phase == SLR_IDLE)
    else $error("digit conversion too slow");

endmodule

`default_nettype wire

//--- dv/slr_conv_model.sv
/*
  Converter model seen by the readout block: start and abort pulses
  in, busy level and split result out.
  Assumes the clock and reset of the block under test.
*/
`timescale 1ns/1ps
`default_nettype none

module slr_conv_model
  import slr_pkg::*;
#(
  parameter int CONV_CYC = 40,
  parameter int SLOW_CYC = 3000
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // Requests and test controls
  input  wire logic        start_i,
  input  wire logic        abort_i,
  input  wire logic        slow_i,
  input  wire logic [9:0]  code_i,
  // Answers
  output logic             busy_o,
  output slr_result_t      result_o
);
  int cnt;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt      <= 0;
      busy_o   <= 1'b0;
      result_o <= '0;
    end else if (abort_i) begin
      cnt    <= 0;
      busy_o <= 1'b0;
    end else if (start_i) begin
      cnt    <= slow_i ? SLOW_CYC : CONV_CYC;
      busy_o <= 1'b1;
    end else if (cnt == 1) begin
      cnt      <= 0;
      busy_o   <= 1'b0;
      // Junk in the unused low bits must not reach the digits
      result_o <= {code_i, 6'h2A};
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule

`default_nettype wire

//--- dv/tb_slr_top.sv
/*
  Self-checking bench for slr_top with a converter model.
  Assumes shortened tick and scan counts set by parameter.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_slr_top;
  import slr_pkg::*;
  localparam int TICK = 2000;
  localparam int SCAN = 16;
  localparam logic [31:0] ZERO = 32'h3FBF3F3F;

  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        slow = 1'b0;
  logic [9:0]  code = 10'h000;
  logic        busy;
  slr_result_t result;
  logic        start;
  logic        abort;
  logic [7:0]  seg;
  logic        sel0;
  logic        sel1;
  int          n_fail = 0;
  int          checked = 0;
  int          cnt;
  // Code beside expected {pos3, pos2, pos1, pos0}
  logic [41:0] rows [6] = '{
    {10'h200, 32'h06BF3F3F}, {10'h3FF, ZERO},
    {10'h064, 32'h6FDB663F}, {10'h000, 32'h40404040},
    {10'h05E, 32'h6FFF6F4F}, {10'h12C, 32'h5BE6064F}};

  always #5 clk_i = ~clk_i;

  slr_top #(.TICK_CYC(TICK), .SCAN_CYC(SCAN)) i_slr_top (
    .clk_i               (clk_i),
    .nrst_i              (nrst_i),
    .conv_busy_i         (busy),
    .conv_result_i       (result),
    .conv_start_o        (start),
    .conv_abort_o        (abort),
    .segment_outputs_o   (seg),
    .digit_select_bit0_o (sel0),
    .digit_select_bit1_o (sel1)
  );

  slr_conv_model i_slr_conv_model (
    .clk_i    (clk_i),
    .nrst_i   (nrst_i),
    .start_i  (start),
    .abort_i  (abort),
    .slow_i   (slow),
    .code_i   (code),
    .busy_o   (busy),
    .result_o (result)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Edges until the signal is seen high, bounded
  task automatic wait_hi(ref logic s, input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (s !== 1'b1 && n < lim);
  endtask

  // Four digit changes: rotation and pattern per position, dwell time on the last three
  task automatic check_disp(input logic [31:0] exp);
    logic [1:0] prev;
    int         n;
    for (int i = 0; i < 4; i++) begin
      prev = {sel1, sel0};
      n = 0;
      do begin
        @(posedge clk_i);
        #1;
        n++;
      end while ({sel1, sel0} === prev && n < SCAN + 4);
      chk({sel1, sel0}, 2'(prev + 2'h1));
      if (i > 0) chk(n, SCAN);
      chk(seg, exp[{sel1, sel0} * 8 +: 8]);
    end
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    #1;
    chk({seg, sel1, sel0, start}, {8'h3F, 3'h0});
    nrst_i = 1'b1;
    check_disp(ZERO);
    wait_hi(start, TICK + 10, cnt);
    foreach (rows[r]) begin
      code = rows[r][41:32];
      wait_hi(start, TICK + 10, cnt);
      wait_hi(start, TICK + 10, cnt);
      chk(cnt, TICK);
      repeat (100) @(posedge clk_i);
      #1;
      check_disp(rows[r][31:0]);
    end
    // Converter still busy at the tick: abort, restart, keep display
    code = 10'h200;
    slow = 1'b1;
    wait_hi(start, TICK + 10, cnt);
    wait_hi(abort, TICK + 10, cnt);
    chk(abort, 1'b1);
    slow = 1'b0;
    @(posedge clk_i);
    #1;
    chk({start, abort}, 2'h2);
    repeat (100) @(posedge clk_i);
    #1;
    check_disp(rows[5][31:0]);
    // Reset in mid-run brings back the 0.00 reset buffer
    nrst_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk({seg, sel1, sel0, start}, {8'h3F, 3'h0});
    nrst_i = 1'b1;
    check_disp(ZERO);
    tally_and_finish();
  end

  // The run needs about fifteen ticks; twenty leaves a margin
  initial begin
    #(TICK * 20 * 10);
    n_fail++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
